// ---- tgc_params.svh ----
// Register offsets, field positions, reset values and timing counts for the timer gate control
`ifndef TGC_PARAMS_SVH
`define TGC_PARAMS_SVH

`define TGC_OFF_GATE_CTRL   12'h000
`define TGC_OFF_MAIN_CTRL   12'h004
`define TGC_BIT_GE          7
`define TGC_BIT_POL         6
`define TGC_BIT_TM          5
`define TGC_BIT_SPM         4
`define TGC_BIT_GO          3
`define TGC_BIT_VAL         2
`define TGC_BIT_SS_HI       1
`define TGC_BIT_SS_LO       0
`define TGC_BIT_TMR_ON      0
`define TGC_RST_GATE_CTRL   8'h00
`define TGC_SYNC_STAGES     3

`endif

// ---- tgc_pkg.sv ----
// Types shared by the timer gate control block
package tgc_pkg;
  typedef enum logic [1:0] {
    TGC_SRC_PIN    = 2'b00,
    TGC_SRC_PAIRED = 2'b01,
    TGC_SRC_CMP1   = 2'b10,
    TGC_SRC_CMP2   = 2'b11
  } tgc_src_t;

  typedef struct packed {
    logic     gate_enable;
    logic     gate_polarity;
    logic     gate_toggle_mode;
    logic     gate_single_pulse_mode;
    tgc_src_t gate_source_select;
  } tgc_cfg_t;

  typedef struct packed {
    logic gate_pin;
    logic paired_match;
    logic cmp1_out;
    logic cmp2_out;
  } tgc_gate_in_t;
endpackage

// ---- tgc_sync.sv ----
// Three-stage synchroniser with agreement filter for asynchronous gate inputs
`timescale 1ns/1ps
`default_nettype none
module tgc_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync_out;

  // Refuse a width that leaves nothing to synchronise
  if (WIDTH < 1) begin : g_width_check
    $error("tgc_sync: WIDTH must be positive");
  end

  // Output moves only once stages two and three agree
  always_comb begin
    next_sync_out = sync_out;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_sync_out[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync_out;
    end
  end
endmodule
`default_nettype wire

// ---- tgc_pulse.sv ----
// Toggle and single-pulse gate stages
`timescale 1ns/1ps
`default_nettype none
module tgc_pulse (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic gate_in,
  input  wire logic toggle_mode,
  input  wire logic single_pulse_mode,
  input  wire logic arm,
  output var  logic status_armed,
  output var  logic gate_out
);
  import tgc_pkg::*;

  typedef enum logic [1:0] {TGC_SP_IDLE, TGC_SP_WAIT, TGC_SP_OPEN} tgc_sp_t;

  logic    gate_prev;
  logic    toggle_ff;
  logic    next_toggle_ff;
  logic    tgl_prev;
  logic    tgl_gate;
  tgc_sp_t sp_state;
  tgc_sp_t next_sp_state;

  // Toggle flip-flop flips on each rising gate edge; cleared while toggle mode is off
  always_comb begin
    next_toggle_ff = toggle_ff;
    if (!toggle_mode) begin
      next_toggle_ff = 1'b0;
    end else if (gate_in && !gate_prev) begin
      next_toggle_ff = !toggle_ff;
    end
  end

  assign tgl_gate = toggle_mode ? toggle_ff : gate_in;

  // Armed acquisition passes exactly one active pulse, then holds gate closed
  always_comb begin
    next_sp_state = sp_state;
    unique case (sp_state)
      TGC_SP_IDLE: begin
        if (arm) next_sp_state = TGC_SP_WAIT;
      end
      TGC_SP_WAIT: begin
        if (tgl_gate && !tgl_prev) next_sp_state = TGC_SP_OPEN;
      end
      TGC_SP_OPEN: begin
        if (!tgl_gate) next_sp_state = TGC_SP_IDLE;
      end
    endcase
    if (!single_pulse_mode) next_sp_state = TGC_SP_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_prev <= 1'b0;
      toggle_ff <= 1'b0;
      tgl_prev  <= 1'b0;
      sp_state  <= TGC_SP_IDLE;
    end else if (ce) begin
      gate_prev <= gate_in;
      toggle_ff <= next_toggle_ff;
      tgl_prev  <= tgl_gate;
      sp_state  <= next_sp_state;
    end
  end

  assign status_armed = (sp_state != TGC_SP_IDLE);
  assign gate_out = single_pulse_mode ? (sp_state == TGC_SP_OPEN && tgl_gate) : tgl_gate;

  a_single_pulse_close: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sp_state == TGC_SP_OPEN && !tgl_gate && single_pulse_mode && !arm
    |=> !status_armed && !gate_out)
    else $error("single pulse did not close the gate");
  a_toggle_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !toggle_mode |=> !toggle_ff)
    else $error("toggle flip-flop not cleared");
  a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn)
    ce && toggle_mode && gate_in && !gate_prev |=> toggle_ff != $past(toggle_ff))
    else $error("toggle flip-flop missed a rising edge");
endmodule
`default_nettype wire

// ---- tgc_gate_ctrl.sv ----
// Timer gate control: APB registers, source select, polarity, toggle and single-pulse gating
`timescale 1ns/1ps
`default_nettype none
`include "tgc_params.svh"
module tgc_gate_ctrl (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output var  logic [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire tgc_pkg::tgc_gate_in_t gate_inputs,
  output var  logic                  count_enable,
  output logic                       lf_osc_request
);
  import tgc_pkg::*;

  tgc_cfg_t     cfg;
  tgc_cfg_t     next_cfg;
  logic         timer_on;
  logic         next_timer_on;
  logic         arm_pulse;
  logic         next_arm_pulse;
  logic [31:0]  next_prdata;
  logic         next_count_enable;
  logic [3:0]   sync_vec;
  tgc_gate_in_t gsync;
  logic         src_level;
  logic         pol_level;
  logic         pulse_gate;
  logic         pulse_armed;
  logic         acc_wr;
  logic         acc_rd;
  logic         hit_gate;
  logic         hit_main;

  // Decode a word address onto one register
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    return (a[11:2] == off[11:2]);
  endfunction

  tgc_sync #(
    .WIDTH (4)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in (gate_inputs),
    .sync_out (sync_vec)
  );
  assign gsync = tgc_gate_in_t'(sync_vec);

  // Paired input is the next timer's period-match strobe
  always_comb begin
    unique case (cfg.gate_source_select)
      TGC_SRC_PIN:    src_level = gsync.gate_pin;
      TGC_SRC_PAIRED: src_level = gsync.paired_match;
      TGC_SRC_CMP1:   src_level = gsync.cmp1_out;
      TGC_SRC_CMP2:   src_level = gsync.cmp2_out;
    endcase
  end

  // Active level normalised to high
  assign pol_level = cfg.gate_polarity ? src_level : !src_level;

  tgc_pulse u_pulse (
    .pclk              (pclk),
    .presetn           (presetn),
    .ce                (ce),
    .gate_in           (pol_level),
    .toggle_mode       (cfg.gate_toggle_mode),
    .single_pulse_mode (cfg.gate_single_pulse_mode),
    .arm               (arm_pulse),
    .status_armed      (pulse_armed),
    .gate_out          (pulse_gate)
  );

  assign acc_wr   = psel && penable && pwrite;
  // Read data is loaded in the setup cycle so it stands through the access phase
  assign acc_rd   = psel && !penable && !pwrite;
  assign hit_gate = addr_hit(paddr, `TGC_OFF_GATE_CTRL);
  assign hit_main = addr_hit(paddr, `TGC_OFF_MAIN_CTRL);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !(hit_gate || hit_main);

  // Register writes; the armed request is a one-cycle pulse
  always_comb begin
    next_cfg       = cfg;
    next_timer_on  = timer_on;
    next_arm_pulse = 1'b0;
    if (acc_wr && pstrb[0] && hit_gate) begin
      next_cfg.gate_enable            = pwdata[`TGC_BIT_GE];
      next_cfg.gate_polarity          = pwdata[`TGC_BIT_POL];
      next_cfg.gate_toggle_mode       = pwdata[`TGC_BIT_TM];
      next_cfg.gate_single_pulse_mode = pwdata[`TGC_BIT_SPM];
      next_cfg.gate_source_select     = tgc_src_t'(pwdata[`TGC_BIT_SS_HI:`TGC_BIT_SS_LO]);
      // Arming only takes effect when single-pulse mode stays on
      next_arm_pulse = pwdata[`TGC_BIT_GO] && pwdata[`TGC_BIT_SPM];
    end
    if (acc_wr && pstrb[0] && hit_main) begin
      next_timer_on = pwdata[`TGC_BIT_TMR_ON];
    end
  end

  // Read data captured at the setup edge
  always_comb begin
    next_prdata = prdata;
    if (acc_rd) begin
      next_prdata = 32'h0000_0000;
      if (hit_gate) begin
        next_prdata[`TGC_BIT_GE]  = cfg.gate_enable;
        next_prdata[`TGC_BIT_POL] = cfg.gate_polarity;
        next_prdata[`TGC_BIT_TM]  = cfg.gate_toggle_mode;
        next_prdata[`TGC_BIT_SPM] = cfg.gate_single_pulse_mode;
        next_prdata[`TGC_BIT_GO]  = pulse_armed;
        next_prdata[`TGC_BIT_VAL] = pulse_gate;
        next_prdata[`TGC_BIT_SS_HI:`TGC_BIT_SS_LO] = cfg.gate_source_select;
      end else if (hit_main) begin
        next_prdata[`TGC_BIT_TMR_ON] = timer_on;
      end
    end
  end

  // Counting permission
  always_comb begin
    next_count_enable = 1'b0;
    if (timer_on) begin
      next_count_enable = cfg.gate_enable ? pulse_gate : 1'b1;
    end
  end

  assign lf_osc_request = cfg.gate_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg          <= tgc_cfg_t'(6'h00);
      timer_on     <= 1'b0;
      arm_pulse    <= 1'b0;
      prdata       <= 32'h0000_0000;
      count_enable <= 1'b0;
    end else if (ce) begin
      cfg          <= next_cfg;
      timer_on     <= next_timer_on;
      arm_pulse    <= next_arm_pulse;
      prdata       <= next_prdata;
      count_enable <= next_count_enable;
    end
  end

  a_timer_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !timer_on |=> !count_enable)
    else $error("counting while timer off");
  a_gate_enabled_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ce && timer_on && cfg.gate_enable |=> count_enable == $past(pulse_gate))
    else $error("count enable does not follow gate");
  a_free_running: assert property (@(posedge pclk) disable iff (!presetn)
    ce && timer_on && !cfg.gate_enable |=> count_enable)
    else $error("timer not counting with gate disabled");
  a_polarity_low: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg.gate_polarity |-> pol_level == !src_level)
    else $error("polarity inversion wrong");
  a_source_cmp2: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.gate_source_select == TGC_SRC_CMP2 |-> src_level == gsync.cmp2_out)
    else $error("source select 11 not comparator 2");
  a_spm_clear_status: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !cfg.gate_single_pulse_mode |=> !pulse_armed)
    else $error("status not cleared with single pulse mode off");
  a_osc_request: assert property (@(posedge pclk) disable iff (!presetn)
    lf_osc_request == cfg.gate_enable)
    else $error("oscillator request mismatch");
  a_read_value: assert property (@(posedge pclk) disable iff (!presetn)
    ce && acc_rd && hit_gate |=> prdata[`TGC_BIT_VAL] == $past(pulse_gate))
    else $error("gate value read wrong");

  c_gated_count: cover property (@(posedge pclk) timer_on && cfg.gate_enable && count_enable);
  c_toggle_run:  cover property (@(posedge pclk) cfg.gate_toggle_mode && pulse_gate);
  c_pulse_done:  cover property (@(posedge pclk) $fell(pulse_armed) && cfg.gate_single_pulse_mode);
endmodule
`default_nettype wire

// ---- tgc_far_side.sv ----
// Far-side model: gate pin, two comparators and the paired timer match output
`timescale 1ns/1ps
`default_nettype none
module tgc_far_side (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [3:0]            lv,
  output var  tgc_pkg::tgc_gate_in_t gate_inputs
);
  import tgc_pkg::*;
  // Levels move just after an edge, unrelated to the bus traffic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_inputs <= '0;
    end else begin
      gate_inputs.gate_pin     <= lv[3];
      gate_inputs.paired_match <= lv[2];
      gate_inputs.cmp1_out     <= lv[1];
      gate_inputs.cmp2_out     <= lv[0];
    end
  end
endmodule
`default_nettype wire

// ---- tgc_gate_ctrl_tb.sv ----
// Self-checking testbench for the timer gate control block
`timescale 1ns/1ps
`default_nettype none
`include "tgc_params.svh"
module tgc_gate_ctrl_tb;
  import tgc_pkg::*;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, rdv;
  logic [3:0]   lv = '0;
  logic         pready, pslverr, count_enable, lf_osc_request, err;
  tgc_gate_in_t gate_inputs;
  int           mismatches = 0, total_checks = 0;

  always #5 pclk = ~pclk;

  tgc_far_side fs (.pclk(pclk), .presetn(presetn), .lv(lv), .gate_inputs(gate_inputs));
  tgc_gate_ctrl uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gate_inputs(gate_inputs),
    .count_enable(count_enable), .lf_osc_request(lf_osc_request));

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    err = pslverr;
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic [7:0] v);
    apb(1'b1, `TGC_OFF_GATE_CTRL, {24'h0, v});
  endtask

  task automatic rd_gate(input logic [7:0] e);
    apb(1'b0, `TGC_OFF_GATE_CTRL, 32'h0);
    chk(rdv, {24'h0, e});
  endtask

  task automatic settle;
    repeat (8) @(posedge pclk);
    #1;
  endtask

  task automatic gate(input logic [3:0] v);
    @(posedge pclk);
    lv <= v;
    settle;
  endtask

  task automatic ce_is(input logic e);
    chk({31'h0, count_enable}, {31'h0, e});
  endtask

  task automatic t_reset;
    apb(1'b0, `TGC_OFF_GATE_CTRL, 32'h0);
    chk(rdv & 32'hFFFF_FFFB, 32'h0);
    apb(1'b0, `TGC_OFF_MAIN_CTRL, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rdv, 32'h0);
    chk({31'h0, lf_osc_request}, 32'h0);
  endtask

  task automatic t_timer_off;
    cfg(8'hC0);
    gate(4'h8);
    ce_is(1'b0);
    chk({31'h0, lf_osc_request}, 32'h1);
    cfg(8'h00);
    settle;
    chk({31'h0, lf_osc_request}, 32'h0);
  endtask

  task automatic t_source;
    logic [3:0] v;
    logic       act;
    apb(1'b1, `TGC_OFF_MAIN_CTRL, 32'h1);
    for (int g = 0; g < 2; g++) begin
      for (int p = 0; p < 2; p++) begin
        for (int s = 0; s < 4; s++) begin
          for (int l = 0; l < 2; l++) begin
            act = (l == p);
            cfg({g[0], p[0], 4'h0, s[1:0]});
            v = {4{~l[0]}};
            v[3 - s] = l[0];
            gate(v);
            ce_is(g ? act : 1'b1);
            rd_gate({g[0], p[0], 3'h0, act, s[1:0]});
          end
        end
      end
    end
  endtask

  task automatic t_toggle;
    cfg(8'hE0);
    gate(4'h0);
    ce_is(1'b0);
    gate(4'h8);
    ce_is(1'b1);
    gate(4'h0);
    ce_is(1'b1);
    gate(4'h8);
    ce_is(1'b0);
    gate(4'h0);
    gate(4'h8);
    ce_is(1'b1);
    cfg(8'hC0);
    cfg(8'hE0);
    settle;
    ce_is(1'b0);
    gate(4'h0);
    gate(4'h8);
    ce_is(1'b1);
  endtask

  task automatic t_pulse;
    cfg(8'hD0);
    gate(4'h0);
    cfg(8'hD8);
    rd_gate(8'hD8);
    ce_is(1'b0);
    gate(4'h8);
    ce_is(1'b1);
    gate(4'h0);
    ce_is(1'b0);
    rd_gate(8'hD0);
    gate(4'h8);
    ce_is(1'b0);
    gate(4'h0);
    cfg(8'hD8);
    rd_gate(8'hD8);
    cfg(8'hC0);
    rd_gate(8'hC0);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_timer_off;
    t_source;
    t_toggle;
    t_pulse;
    close_out;
  end

  initial begin
    #300000;
    mismatches++;
    close_out;
  end
endmodule
`default_nettype wire
